// ===== rtl/clock_buffer_pkg.sv
package clock_buffer_pkg;
    // number of gated clock outputs
    localparam int NUM_OUT_DEF = 12;
    // register space: byte count and index width
    localparam int NUM_REG = 8;
    localparam int REG_AW = 7;
    // slave addresses chosen by the latched select level
    localparam logic [6:0] SLAVE_ADDR_SEL0 = 7'h69;
    localparam logic [6:0] SLAVE_ADDR_SEL1 = 7'h6a;
    // enable register indices and bit layout
    localparam int REG_EN_LO = 0;
    localparam int REG_EN_HI = 1;
    localparam int EN_LO_WIDTH = 8;
    localparam int EN_HI_FIRST_BIT = 4;
    // reset contents, byte 0 in the low bits
    localparam logic [NUM_REG*8-1:0] REG_RESET_VEC = 64'h0000_0000_0000_f0ff;
    // writable bits; reserved bits stay zero
    localparam logic [NUM_REG*8-1:0] REG_WMASK_VEC = 64'hffff_ffff_ff00_f0ff;
    // command byte: mode bit selects byte access when set
    localparam int CMD_BYTE_MODE_BIT = 7;
    // byte count returned first in a block read
    localparam logic [7:0] BLOCK_READ_COUNT = 8'h06;
    // bits per serial byte
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // wake time after power-down release, in its own unit
    localparam int CLK_MHZ = 250;
    localparam int WAKE_TIME_US = 520;
    // longest time rounds down to whole cycles
    localparam int WAKE_CYCLES_DEF = WAKE_TIME_US * CLK_MHZ;
    localparam int WAKE_CNT_W = 18;

    // serial slave states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_CMD,
        ST_CMD_ACK,
        ST_CNT,
        ST_CNT_ACK,
        ST_WDATA,
        ST_WACK,
        ST_RDATA,
        ST_RACK
    } i2c_state_t;
endpackage : clock_buffer_pkg

// ===== rtl/reg_byte_store.sv
`timescale 1ns/1ns
module reg_byte_store
    import clock_buffer_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // write port
    input wire logic wr_en_in,
    input wire logic [REG_AW-1:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    // read port, data one cycle later
    input wire logic [REG_AW-1:0] rd_addr_in,
    output logic [7:0] rd_data_out,
    // all bytes, flat
    output logic [NUM_REG*8-1:0] contents_out
);

    // whole state of the store
    typedef struct packed {
        logic [NUM_REG-1:0][7:0] mem;
        logic [7:0] rd_data;
    } store_t;

    store_t s_q;
    store_t s_d;

    // write with reserved-bit mask, registered read
    always_comb
    begin
        s_d = s_q;
        // out-of-range index reads zero
        s_d.rd_data = 8'h00;
        for (int i = 0; i < NUM_REG; i++)
        begin
            if (wr_en_in && wr_addr_in == REG_AW'(i))
            begin
                // masked bits keep their reset value
                s_d.mem[i] = (wr_data_in & REG_WMASK_VEC[i*8 +: 8])
                    | (REG_RESET_VEC[i*8 +: 8] & ~REG_WMASK_VEC[i*8 +: 8]);
            end
            if (rd_addr_in == REG_AW'(i))
            begin
                s_d.rd_data = s_q.mem[i];
            end
        end
    end

    // register the state; defaults load at reset
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            s_q.mem <= REG_RESET_VEC;
            s_q.rd_data <= 8'h00;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rd_data_out = s_q.rd_data;
    assign contents_out = s_q.mem;

endmodule : reg_byte_store

// ===== rtl/clock_buffer_output_ctrl.sv
`timescale 1ns/1ns
// What this block does
// - output runs only when pin low, bit set
// - defaults: stop pin low, enable bits one
// - start/stop per output, others unaffected
// - resumed output has no short or long pulse
// - stopped output ends cleanly, then held low
// - start or stop within 3.5 input clocks
// - select pin latched at power-up, open reads one
// - address 1101001 for zero, 1101010 for one
// - power-down pin low enters power-down mode
// - power-down stops all outputs glitch-free, low
// - power-down also disables serial slave
// - outputs return just after 520 us from release
// - registers load defaults; serial use optional
// - block bytes ascending, msb first, stop anytime
// - block read returns count 06h then data
// - block write command gives start index
// - command 00h behaves as plain block mode
// - device acks every received write byte
// - byte read: restart, data, nack, stop
// - command top bit: one byte, zero block
// - each output has own enable bit, default one
module clock_buffer_output_ctrl
    import clock_buffer_pkg::*;
#(
    parameter int NUM_OUT = NUM_OUT_DEF,
    parameter int WAKE_CYCLES = WAKE_CYCLES_DEF
)
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // input reference clock, sampled
    input wire logic ref_clk_in,
    // board control pins
    input wire logic [NUM_OUT-1:0] output_stop_pin_n_in,
    input wire logic power_down_pin_n_in,
    input wire logic slave_address_select_pin_in,
    // serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // gated differential clocks
    output logic [NUM_OUT-1:0] differential_clock_output_p_out,
    output logic [NUM_OUT-1:0] differential_clock_output_n_out,
    // status
    output logic [NUM_OUT-1:0] output_running_out,
    output logic awake_out
);

    localparam int REG_BITS = NUM_REG * 8;

    // whole state of the block
    typedef struct packed {
        // synchronisers, two stages, plus a third on ref, scl and sda for edges
        logic ref_s1;
        logic ref_s2;
        logic ref_s3;
        logic [NUM_OUT-1:0] stop_s1;
        logic [NUM_OUT-1:0] stop_s2;
        logic pd_s1;
        logic pd_s2;
        logic sa_s1;
        logic sa_s2;
        logic scl_s1;
        logic scl_s2;
        logic scl_s3;
        logic sda_s1;
        logic sda_s2;
        logic sda_s3;
        // latched address select
        logic sa_taken;
        logic sa_level;
        // power-down and wake
        logic awake;
        logic [WAKE_CNT_W-1:0] wake_cnt;
        // output gating
        logic [NUM_OUT-1:0] gate;
        logic [NUM_OUT-1:0] clk_p;
        logic [NUM_OUT-1:0] clk_n;
        // serial slave
        i2c_state_t st;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic [7:0] tx;
        logic rw;
        logic byte_mode;
        logic first;
        logic [7:0] remain;
        logic [REG_AW-1:0] ptr;
        logic sda_oe;
        logic sda_level;
    } state_t;

    state_t s_q;
    state_t s_d;

    // register store wiring
    logic wr_en;
    logic [7:0] rd_data;
    logic [REG_BITS-1:0] contents;
    // bus events
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic ref_fall;
    logic [6:0] own_addr;

    // enable bit of one output from the register contents
    function automatic logic en_bit(input logic [REG_BITS-1:0] c, input int i);
        if (i < EN_LO_WIDTH)
        begin
            return c[REG_EN_LO*8 + i];
        end
        return c[REG_EN_HI*8 + EN_HI_FIRST_BIT + i - EN_LO_WIDTH];
    endfunction : en_bit

    // register byte store
    reg_byte_store i_reg_byte_store (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .wr_en_in(wr_en),
        .wr_addr_in(s_q.ptr),
        .wr_data_in(s_q.shreg),
        .rd_addr_in(s_q.ptr),
        .rd_data_out(rd_data),
        .contents_out(contents)
    );

    // next-state logic for the whole block
    always_comb
    begin
        s_d = s_q;
        wr_en = 1'b0;

        // two-stage synchronisers for every outside input
        s_d.ref_s1 = ref_clk_in;
        s_d.ref_s2 = s_q.ref_s1;
        s_d.ref_s3 = s_q.ref_s2;
        s_d.stop_s1 = output_stop_pin_n_in;
        s_d.stop_s2 = s_q.stop_s1;
        s_d.pd_s1 = power_down_pin_n_in;
        s_d.pd_s2 = s_q.pd_s1;
        s_d.sa_s1 = slave_address_select_pin_in;
        s_d.sa_s2 = s_q.sa_s1;
        s_d.scl_s1 = scl_in;
        s_d.scl_s2 = s_q.scl_s1;
        s_d.scl_s3 = s_q.scl_s2;
        s_d.sda_s1 = sda_in;
        s_d.sda_s2 = s_q.sda_s1;
        s_d.sda_s3 = s_q.sda_s2;

        // edges seen on the synchronised lines
        ref_fall = s_q.ref_s3 & ~s_q.ref_s2;
        scl_rise = s_q.scl_s2 & ~s_q.scl_s3;
        scl_fall = ~s_q.scl_s2 & s_q.scl_s3;
        bus_start = s_q.scl_s2 & s_q.scl_s3 & s_q.sda_s3 & ~s_q.sda_s2;
        bus_stop = s_q.scl_s2 & s_q.scl_s3 & ~s_q.sda_s3 & s_q.sda_s2;

        // catch the select level once, on first power-up
        if (!s_q.sa_taken && s_q.pd_s2)
        begin
            s_d.sa_taken = 1'b1;
            s_d.sa_level = s_q.sa_s2;
        end
        own_addr = s_q.sa_level ? SLAVE_ADDR_SEL1 : SLAVE_ADDR_SEL0;

        // power-down drops awake at once; release starts the wake count
        if (!s_q.pd_s2)
        begin
            s_d.awake = 1'b0;
            s_d.wake_cnt = '0;
        end
        else if (!s_q.awake)
        begin
            // wake lands once the full wake count has run, just past the longest time
            if (s_q.wake_cnt == WAKE_CNT_W'(WAKE_CYCLES - 1))
            begin
                s_d.awake = 1'b1;
            end
            else
            begin
                s_d.wake_cnt = s_q.wake_cnt + 1'b1;
            end
        end

        // per-output gate changes only at a falling input edge
        for (int i = 0; i < NUM_OUT; i++)
        begin
            if (ref_fall)
            begin
                // run only with pin low, bit set, and awake
                s_d.gate[i] = ~s_q.stop_s2[i] & en_bit(contents, i) & s_q.awake;
            end
            // p ends a full high, n starts a full low: no runt pulses
            s_d.clk_p[i] = s_q.ref_s2 & s_d.gate[i];
            s_d.clk_n[i] = ~s_q.ref_s2 & s_d.gate[i];
        end

        // serial slave, held idle and released while powered down
        if (!s_q.pd_s2)
        begin
            s_d.st = ST_IDLE;
            s_d.sda_oe = 1'b0;
        end
        else if (bus_start)
        begin
            // start or repeated start begins a new address phase
            s_d.st = ST_ADDR;
            s_d.bit_cnt = '0;
            s_d.sda_oe = 1'b0;
        end
        else if (bus_stop)
        begin
            // stop ends any transfer after any byte
            s_d.st = ST_IDLE;
            s_d.sda_oe = 1'b0;
        end
        else if (scl_rise)
        begin
            unique case (s_q.st)
                ST_ADDR, ST_CMD, ST_CNT, ST_WDATA:
                begin
                    // shift in msb first
                    s_d.shreg = {s_q.shreg[6:0], s_q.sda_s2};
                    s_d.bit_cnt = s_q.bit_cnt + 1'b1;
                end
                ST_RACK:
                begin
                    // not-acknowledge ends the read
                    if (s_q.sda_s2)
                    begin
                        s_d.st = ST_IDLE;
                    end
                end
                default:
                begin
                    s_d.st = s_q.st;
                end
            endcase
        end
        else if (scl_fall)
        begin
            unique case (s_q.st)
                ST_ADDR:
                begin
                    if (s_q.bit_cnt == BITS_PER_BYTE)
                    begin
                        s_d.bit_cnt = '0;
                        // acknowledge only our own address
                        if (s_q.shreg[7:1] == own_addr)
                        begin
                            s_d.rw = s_q.shreg[0];
                            s_d.sda_oe = 1'b1;
                            s_d.st = ST_ADDR_ACK;
                        end
                        else
                        begin
                            s_d.st = ST_IDLE;
                        end
                    end
                end
                ST_CMD:
                begin
                    if (s_q.bit_cnt == BITS_PER_BYTE)
                    begin
                        // top bit picks byte or block mode
                        s_d.byte_mode = s_q.shreg[CMD_BYTE_MODE_BIT];
                        // low seven bits give the start index
                        s_d.ptr = s_q.shreg[REG_AW-1:0];
                        s_d.first = 1'b1;
                        // byte mode moves a single register
                        s_d.remain = 8'h01;
                        s_d.bit_cnt = '0;
                        s_d.sda_oe = 1'b1;
                        s_d.st = ST_CMD_ACK;
                    end
                end
                ST_CNT:
                begin
                    if (s_q.bit_cnt == BITS_PER_BYTE)
                    begin
                        // data bytes beyond the count are acked, not stored
                        s_d.remain = s_q.shreg;
                        s_d.bit_cnt = '0;
                        s_d.sda_oe = 1'b1;
                        s_d.st = ST_CNT_ACK;
                    end
                end
                ST_WDATA:
                begin
                    if (s_q.bit_cnt == BITS_PER_BYTE)
                    begin
                        if (s_q.remain != 8'h00)
                        begin
                            // store and step to the next index
                            wr_en = 1'b1;
                            s_d.ptr = s_q.ptr + 1'b1;
                            s_d.remain = s_q.remain - 1'b1;
                        end
                        s_d.bit_cnt = '0;
                        s_d.sda_oe = 1'b1;
                        s_d.st = ST_WACK;
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (s_q.rw)
                    begin
                        // block read sends its count first
                        if (!s_q.byte_mode && s_q.first)
                        begin
                            s_d.tx = BLOCK_READ_COUNT;
                        end
                        else
                        begin
                            s_d.tx = rd_data;
                            s_d.ptr = s_q.ptr + 1'b1;
                        end
                        s_d.first = 1'b0;
                        s_d.sda_oe = ~s_d.tx[7];
                        s_d.bit_cnt = 4'h1;
                        s_d.st = ST_RDATA;
                    end
                    else
                    begin
                        s_d.sda_oe = 1'b0;
                        s_d.st = ST_CMD;
                    end
                end
                ST_CMD_ACK:
                begin
                    // block mode expects a count next
                    s_d.sda_oe = 1'b0;
                    s_d.st = s_q.byte_mode ? ST_WDATA : ST_CNT;
                end
                ST_CNT_ACK, ST_WACK:
                begin
                    s_d.sda_oe = 1'b0;
                    s_d.st = ST_WDATA;
                end
                ST_RDATA:
                begin
                    if (s_q.bit_cnt == BITS_PER_BYTE)
                    begin
                        // release for the controller's answer
                        s_d.sda_oe = 1'b0;
                        s_d.bit_cnt = '0;
                        s_d.st = ST_RACK;
                    end
                    else
                    begin
                        // next bit, msb first
                        s_d.sda_oe = ~s_q.tx[6];
                        s_d.tx = {s_q.tx[6:0], 1'b0};
                        s_d.bit_cnt = s_q.bit_cnt + 1'b1;
                    end
                end
                ST_RACK:
                begin
                    // acked: send the next register in ascending order
                    s_d.tx = rd_data;
                    s_d.ptr = s_q.ptr + 1'b1;
                    s_d.sda_oe = ~rd_data[7];
                    s_d.bit_cnt = 4'h1;
                    s_d.st = ST_RDATA;
                end
                default:
                begin
                    s_d.st = s_q.st;
                end
            endcase
        end
    end

    // register the whole state
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // outputs straight from state flops
    assign sda_out = s_q.sda_level;
    assign sda_oe_out = s_q.sda_oe;
    assign differential_clock_output_p_out = s_q.clk_p;
    assign differential_clock_output_n_out = s_q.clk_n;
    assign output_running_out = s_q.gate;
    assign awake_out = s_q.awake;

endmodule : clock_buffer_output_ctrl

// ===== tb/clock_buffer_output_ctrl_checker.sv
`timescale 1ns/1ns
module clock_buffer_output_ctrl_checker
    import clock_buffer_pkg::*;
#(
    parameter int NUM_OUT = NUM_OUT_DEF,
    parameter int WAKE_CYCLES = WAKE_CYCLES_DEF
)
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // watched inputs
    input wire logic ref_clk_in,
    input wire logic [NUM_OUT-1:0] output_stop_pin_n_in,
    input wire logic power_down_pin_n_in,
    // watched outputs
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic [NUM_OUT-1:0] differential_clock_output_p_out,
    input wire logic [NUM_OUT-1:0] differential_clock_output_n_out,
    input wire logic [NUM_OUT-1:0] output_running_out,
    input wire logic awake_out
);
    // cycles with power-down pin high, saturating
    int hi_q;
    // cycles with stop pin 2 high, saturating
    int st_q;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    // cycle counters for the long waits
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            hi_q <= 0;
            st_q <= 0;
        end
        else
        begin
            hi_q <= !power_down_pin_n_in ? 0 : (hi_q < 200000 ? hi_q + 1 : hi_q);
            st_q <= !output_stop_pin_n_in[2] ? 0 : (st_q < 200 ? st_q + 1 : st_q);
        end
    end
    a_stopped_low: assert property (((differential_clock_output_p_out |
        differential_clock_output_n_out) & ~output_running_out & ~$past(output_running_out)) == '0)
        else $error("stopped output not held low");
    a_pn_exclusive: assert property ((differential_clock_output_p_out &
        differential_clock_output_n_out) == '0)
        else $error("true and complement high together");
    a_p_full_high: assert property ($rose(differential_clock_output_p_out[0]) |->
        differential_clock_output_p_out[0] [*8])
        else $error("short high pulse");
    a_n_full_high: assert property ($rose(differential_clock_output_n_out[0]) |->
        differential_clock_output_n_out[0] [*8])
        else $error("short low-phase pulse");
    a_gate_low_phase: assert property ($changed(output_running_out) |-> !ref_clk_in)
        else $error("gate changed in high phase");
    a_p_after_ref: assert property ($rose(differential_clock_output_p_out[0]) |->
        $past(ref_clk_in, 2))
        else $error("output rise without reference rise");
    a_stop_latency: assert property (st_q == 109 |-> !output_running_out[2])
        else $error("stop not applied in time");
    a_start_needs_pin: assert property ($rose(output_running_out[2]) |->
        !$past(output_stop_pin_n_in[2], 2))
        else $error("output started while stop pin high");
    a_pd_quiet: assert property (!power_down_pin_n_in [*4] |=> !awake_out && !sda_oe_out)
        else $error("activity in power-down");
    a_wake_early: assert property ($rose(awake_out) |-> hi_q >= WAKE_CYCLES)
        else $error("woke too early");
    a_wake_bound: assert property (hi_q == WAKE_CYCLES + 10 |-> awake_out)
        else $error("woke too late");
    a_sda_open_drain: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    // main scenarios reached
    c_awake: cover property ($rose(awake_out));
    c_ack: cover property ($rose(sda_oe_out));
    c_gate_off: cover property ($fell(output_running_out[2]));
endmodule : clock_buffer_output_ctrl_checker

bind clock_buffer_output_ctrl clock_buffer_output_ctrl_checker #(
    .NUM_OUT(NUM_OUT),
    .WAKE_CYCLES(WAKE_CYCLES)
) i_clock_buffer_output_ctrl_checker (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .ref_clk_in(ref_clk_in),
    .output_stop_pin_n_in(output_stop_pin_n_in),
    .power_down_pin_n_in(power_down_pin_n_in),
    .sda_out(sda_out),
    .sda_oe_out(sda_oe_out),
    .differential_clock_output_p_out(differential_clock_output_p_out),
    .differential_clock_output_n_out(differential_clock_output_n_out),
    .output_running_out(output_running_out),
    .awake_out(awake_out)
);

// ===== tb/i2c_bus_board_model.sv
`timescale 1ns/1ns
module i2c_bus_board_model
(
    // line drives
    input wire logic sda_master_in,
    input wire logic sda_oe_in,
    input wire logic sda_level_in,
    // board signals
    output logic ref_clk_out,
    output wire logic sda_wire_out
);
    // free-running reference clock, 125 ns period
    // edges land late in the time step, so a system clock edge at the
    // same instant samples the old level in the design and the checker alike
    initial
    begin
        ref_clk_out = 1'b0;
        forever
        begin
            #62 ref_clk_out <= 1'b1;
            #63 ref_clk_out <= 1'b0;
        end
    end
    // open-drain wire with pull-up: low while either side pulls
    assign sda_wire_out = sda_master_in & (sda_oe_in ? sda_level_in : 1'b1);
endmodule : i2c_bus_board_model

// ===== tb/clock_buffer_output_ctrl_bench.sv
`timescale 1ns/1ns
module clock_buffer_output_ctrl_bench;
    // half bit time of the serial bus, in clocks
    localparam int HB = 16;
    logic clk;
    logic rst = 1'b1;
    // board pins; stop pins rest low as with the pull-down
    logic [11:0] stop_n = 12'h000;
    logic pd_n = 1'b1;
    logic sel = 1'b1;
    logic scl = 1'b1;
    logic sda_m = 1'b1;
    wire ref_clk;
    wire sda_w;
    wire sda_drv;
    wire sda_oe;
    wire [11:0] clk_p;
    wire [11:0] clk_n;
    wire [11:0] run;
    wire awake;
    // bytes sent after the command, bytes read back
    logic [7:0] wq[$];
    logic [7:0] rq[8];
    logic [6:0] adr;
    int n_fail = 0;
    int n_checks = 0;

    clock_buffer_output_ctrl #(.NUM_OUT(12), .WAKE_CYCLES(20)) i_clock_buffer_output_ctrl (
        .sys_clk_in(clk), .reset_in(rst), .ref_clk_in(ref_clk),
        .output_stop_pin_n_in(stop_n), .power_down_pin_n_in(pd_n),
        .slave_address_select_pin_in(sel), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_drv), .sda_oe_out(sda_oe),
        .differential_clock_output_p_out(clk_p), .differential_clock_output_n_out(clk_n),
        .output_running_out(run), .awake_out(awake));
    i2c_bus_board_model i_i2c_bus_board_model (.sda_master_in(sda_m), .sda_oe_in(sda_oe),
        .sda_level_in(sda_drv), .ref_clk_out(ref_clk), .sda_wire_out(sda_w));

    // 250 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    // one bit: data set in low phase, line sampled late in high phase
    task automatic bitx(input logic b, output logic r);
        scl <= 1'b0;
        cyc(4);
        sda_m <= b;
        cyc(HB);
        scl <= 1'b1;
        cyc(HB);
        r = sda_w;
    endtask : bitx
    // start or repeated start, then stop
    task automatic start_c();
        scl <= 1'b0;
        cyc(4);
        sda_m <= 1'b1;
        cyc(HB);
        scl <= 1'b1;
        cyc(HB);
        sda_m <= 1'b0;
        cyc(HB);
    endtask : start_c
    task automatic stop_c();
        scl <= 1'b0;
        cyc(4);
        sda_m <= 1'b0;
        cyc(HB);
        scl <= 1'b1;
        cyc(HB);
        sda_m <= 1'b1;
        cyc(HB);
    endtask : stop_c
    // byte out msb first, ack returned
    task automatic send(input logic [7:0] d, output logic ak);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(d[i], r);
        bitx(1'b1, r);
        ak = !r;
    endtask : send
    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(1'b1, d[i]);
        bitx(last, r);
    endtask : recv
    // write address, command, queued bytes; then optional read of nr bytes
    task automatic xfer(input logic [6:0] a, input logic [7:0] cmd, input int nr,
                        input logic ak);
        logic k;
        start_c();
        send({a, 1'b0}, k);
        check(k, ak);
        if (ak)
        begin
            send(cmd, k);
            check(k, 1'b1);
            foreach (wq[i])
            begin
                send(wq[i], k);
                check(k, 1'b1);
            end
            if (nr > 0)
            begin
                start_c();
                send({a, 1'b1}, k);
                check(k, 1'b1);
                for (int i = 0; i < nr; i++)
                    recv(i == nr - 1, rq[i]);
            end
        end
        stop_c();
    endtask : xfer
    task automatic wait_awake(input int lim);
        int k;
        k = 0;
        while (awake !== 1'b1 && k < lim)
        begin
            cyc(1);
            k++;
        end
        check(awake, 1'b1);
    endtask : wait_awake

    // main sequence
    initial
    begin
        cyc(1);
        for (int s = 0; s < 2; s++)
        begin
            sel <= s[0];
            rst <= 1'b1;
            cyc(5);
            rst <= 1'b0;
            wait_awake(60);
            cyc(110);
            check(run, 12'hfff);
            adr = s ? 7'h6a : 7'h69;
            xfer(s ? 7'h69 : 7'h6a, 8'h80, 0, 1'b0);
            xfer(adr, 8'h81, 1, 1'b1);
            check(rq[0], 8'hf0);
        end
        // select pin moves after the latch: address must stay as latched
        sel <= 1'b0;
        wq = {8'h02, 8'h0f, 8'h30};
        xfer(adr, 8'h00, 0, 1'b1);
        cyc(110);
        check(run, 12'h30f);
        wq = {};
        xfer(adr, 8'h00, 3, 1'b1);
        check(rq[0], 8'h06);
        check({rq[1], rq[2]}, 16'h0f30);
        wq = {8'h01, 8'hf0};
        xfer(adr, 8'h01, 0, 1'b1);
        wq = {8'hfe};
        xfer(adr, 8'h80, 0, 1'b1);
        cyc(110);
        check(run, 12'hffe);
        stop_n <= 12'h004;
        cyc(110);
        check(run, 12'hffa);
        stop_n <= 12'h000;
        cyc(110);
        check(run, 12'hffe);
        pd_n <= 1'b0;
        cyc(110);
        check({awake, run}, {1'b0, 12'h000});
        xfer(adr, 8'h80, 0, 1'b0);
        pd_n <= 1'b1;
        wait_awake(60);
        cyc(110);
        check(run, 12'hffe);
        wq = {};
        xfer(adr, 8'h80, 1, 1'b1);
        check(rq[0], 8'hfe);
        tally_and_finish();
    end
    // watchdog against a hang
    initial
    begin
        #300000;
        n_fail++;
        tally_and_finish();
    end
endmodule : clock_buffer_output_ctrl_bench
